/* verilog/sdc_defines.svh */
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// Frame geometry
`define SDC_FRAME_BITS 24
`define SDC_CNT_W 5
`define SDC_CNT_MAX 5'h1f

// Input register fields
`define SDC_BIT_SEL 0
`define SDC_BIT_DRV_LO 1
`define SDC_BIT_DRV_HI 17
`define SDC_BIT_CM_LO 18
`define SDC_BIT_CM_HI 19
`define SDC_BIT_SUPPLY_LATCH 20
`define SDC_BIT_RETRY_DUTY 21
`define SDC_BIT_CLEAR 22
`define SDC_BIT_ENABLE 23

// Status register fields
`define SDC_ST_FAULT 0
`define SDC_ST_OC_LO 1
`define SDC_ST_OC_HI 17
`define SDC_ST_NOT_READY 18
`define SDC_ST_TW 19
`define SDC_ST_TSD 20
`define SDC_ST_UV 21
`define SDC_ST_OV 22
`define SDC_ST_ALWAYS1 23
`define SDC_ST_FLAG_LO 1
`define SDC_ST_FLAG_HI 22

// Widths and reset values
`define SDC_DRV_N 17
`define SDC_OL_N 22
`define SDC_EVT_N 43
`define SDC_WORD_RST 24'h000000

// Timing
`define SDC_CLK_NS 10
`define SDC_STARTUP_NS 1000
`define SDC_STARTUP_CYC ((`SDC_STARTUP_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_STARTUP_W 8

`endif

/* verilog/sdc_pkg.sv */
package sdc_pkg;
    typedef logic [23:0] sdc_word_t;
    typedef enum logic [0:0] {
        sdc_idle = 1'b0,
        sdc_frame = 1'b1
    } sdc_state_t;
endpackage

/* verilog/sdc_sync.sv */
module sdc_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Two-stage capture, first stage read only by second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // sdc_sync

/* verilog/sdc_fault.sv */
`include "sdc_defines.svh"

module sdc_fault (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`SDC_DRV_N-1:0] oc_set,
    input wire logic tw_set,
    input wire logic tsd_set,
    input wire logic uv_set,
    input wire logic ov_set,
    input wire logic [`SDC_OL_N-1:0] ol_set,
    input wire logic not_ready,
    input wire logic clear,
    output sdc_pkg::sdc_word_t st0,
    output sdc_pkg::sdc_word_t st1,
    output logic fault
);
    import sdc_pkg::*;

    logic [`SDC_DRV_N-1:0] oc_q, oc_d;
    logic [`SDC_OL_N-1:0] ol_q, ol_d;
    logic tw_q, tw_d, tsd_q, tsd_d, uv_q, uv_d, ov_q, ov_d;

    // Sticky flags, a live event beats a clear
    always_comb begin
        oc_d = (oc_q & ~{`SDC_DRV_N{clear}}) | oc_set;
        ol_d = (ol_q & ~{`SDC_OL_N{clear}}) | ol_set;
        tw_d = (tw_q & ~clear) | tw_set;
        tsd_d = (tsd_q & ~clear) | tsd_set;
        uv_d = (uv_q & ~clear) | uv_set;
        ov_d = (ov_q & ~clear) | ov_set;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            oc_q <= '0;
            ol_q <= '0;
            tw_q <= 1'b0;
            tsd_q <= 1'b0;
            uv_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            oc_q <= oc_d;
            ol_q <= ol_d;
            tw_q <= tw_d;
            tsd_q <= tsd_d;
            uv_q <= uv_d;
            ov_q <= ov_d;
        end
    end

    // Status word assembly and fault summary
    always_comb begin
        st0 = `SDC_WORD_RST;
        st1 = `SDC_WORD_RST;
        st0[`SDC_ST_OC_HI:`SDC_ST_OC_LO] = oc_q;
        st0[`SDC_ST_NOT_READY] = not_ready;
        st0[`SDC_ST_TW] = tw_q;
        st0[`SDC_ST_TSD] = tsd_q;
        st0[`SDC_ST_UV] = uv_q;
        st0[`SDC_ST_OV] = ov_q;
        st0[`SDC_ST_ALWAYS1] = 1'b1;
        st1[`SDC_ST_FLAG_HI:`SDC_ST_FLAG_LO] = ol_q;
        fault = (|st0[`SDC_ST_FLAG_HI:`SDC_ST_FLAG_LO]) | (|st1[`SDC_ST_FLAG_HI:`SDC_ST_FLAG_LO]);
        st0[`SDC_ST_FAULT] = fault;
        st1[`SDC_ST_FAULT] = fault;
    end
endmodule // sdc_fault

/* verilog/sdc_top.sv */
// Contract
// - Mode 0: sample rising, change falling
// - Words travel least significant bit first
// - Chip select low drives fault bit out
// - Fault bit combines status bits 1-22
// - Output released while chip select high
// - Frame spans chip select low period
// - Input bits shift into 24-bit register
// - Commit only on exactly 24 pulses
// - First rising edge loads status word
// - Bit 0 selects register pair
// - Bits 1-17 switch drivers
// - Bit 23 active, zero means standby
// - Reset starts in standby
// - Bits 18-19 select current monitor
// - Bit 22 clears both status registers
// - Overcurrent disables its driver (code leaves it on while its retry enable bit in register 1 is set)
// - Thermal shutdown releases all drivers
// - Status 0 bit 23 reads one
// - Supply fault flags and deactivates outputs
// - Bit 20 holds outputs off after recovery
// - Bit 21 picks retry duty
`include "sdc_defines.svh"

module sdc_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe_n,
    input wire logic [`SDC_DRV_N-1:0] overcurrent_evt,
    input wire logic temp_warn_evt,
    input wire logic thermal_shutdown_evt,
    input wire logic undervoltage_evt,
    input wire logic overvoltage_evt,
    input wire logic [`SDC_OL_N-1:0] openload_evt,
    output logic [`SDC_DRV_N-1:0] driver_on,
    output logic [1:0] current_monitor_output,
    output logic overcurrent_retry_duty,
    output logic [`SDC_DRV_N-1:0] overcurrent_retry_en,
    output logic active_mode
);
    import sdc_pkg::*;

    logic [2:0] link_s;
    logic [`SDC_EVT_N-1:0] evt_s;
    logic csn_s, sck_s, sdi_s;
    logic csn_prev_q, csn_prev_d, sck_prev_q, sck_prev_d;
    logic csn_fall, csn_rise, sck_rise, sck_fall;
    sdc_state_t state_q, state_d;
    logic [`SDC_CNT_W-1:0] cnt_q, cnt_d;
    sdc_word_t shin_q, shin_d, shout_q, shout_d;
    sdc_word_t ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d;
    sdc_word_t st0, st1;
    logic loaded_q, loaded_d;
    logic sdo_q, sdo_d, oe_n_q, oe_n_d;
    logic active_q, active_d;
    logic [`SDC_STARTUP_W-1:0] nr_q, nr_d;
    logic not_ready, fault, commit, clear;
    logic [`SDC_DRV_N-1:0] drv_q, drv_d;
    logic [`SDC_DRV_N-1:0] oc_flags, retry_en;
    logic tsd_flag, supply_block;

    // Link pins and fault events cross into clk_sys
    sdc_sync #(.W(3)) u_link_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({~chip_select_n, serial_clk, serial_in}), // Select inverted so reset flushes to idle
        .sync_out(link_s)
    );

    sdc_sync #(.W(`SDC_EVT_N)) u_evt_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({overcurrent_evt, temp_warn_evt, thermal_shutdown_evt, undervoltage_evt,
                   overvoltage_evt, openload_evt}),
        .sync_out(evt_s)
    );

    // Status flags and fault summary
    sdc_fault u_fault (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .oc_set(evt_s[`SDC_EVT_N-1 -: `SDC_DRV_N]),
        .tw_set(evt_s[`SDC_OL_N+3]),
        .tsd_set(evt_s[`SDC_OL_N+2]),
        .uv_set(evt_s[`SDC_OL_N+1]),
        .ov_set(evt_s[`SDC_OL_N]),
        .ol_set(evt_s[`SDC_OL_N-1:0]),
        .not_ready(not_ready),
        .clear(clear),
        .st0(st0),
        .st1(st1),
        .fault(fault)
    );

    // Edge detection on synchronised link signals
    always_comb begin
        csn_s = ~link_s[2];
        sck_s = link_s[1];
        sdi_s = link_s[0];
        csn_prev_d = csn_s;
        sck_prev_d = sck_s;
        csn_fall = csn_prev_q & ~csn_s;
        csn_rise = ~csn_prev_q & csn_s;
        sck_rise = ~sck_prev_q & sck_s & ~csn_s;
        sck_fall = sck_prev_q & ~sck_s & ~csn_s;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            csn_prev_q <= 1'b1;
            sck_prev_q <= 1'b0;
        end else begin
            csn_prev_q <= csn_prev_d;
            sck_prev_q <= sck_prev_d;
        end
    end

    // Frame engine: shift in, shift out, count pulses
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shin_d = shin_q;
        shout_d = shout_q;
        loaded_d = loaded_q;
        sdo_d = sdo_q;
        oe_n_d = csn_s;
        commit = 1'b0;
        unique case (state_q)
            sdc_idle: begin
                if (csn_fall) begin
                    state_d = sdc_frame;
                    cnt_d = '0;
                    loaded_d = 1'b0;
                end
                sdo_d = fault;
            end
            sdc_frame: begin
                if (csn_rise) begin
                    state_d = sdc_idle;
                    commit = (cnt_q == `SDC_CNT_W'(`SDC_FRAME_BITS));
                end else begin
                    if (sck_rise) begin
                        shin_d = {sdi_s, shin_q[`SDC_FRAME_BITS-1:1]};
                        if (cnt_q != `SDC_CNT_MAX) begin
                            cnt_d = cnt_q + `SDC_CNT_W'(1);
                        end
                        if (!loaded_q) begin
                            shout_d = sdi_s ? st1 : st0;
                            loaded_d = 1'b1;
                        end
                    end
                    if (sck_fall && loaded_q) begin
                        shout_d = {1'b0, shout_q[`SDC_FRAME_BITS-1:1]};
                        sdo_d = shout_q[1];
                    end else if (!loaded_q) begin
                        sdo_d = fault;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= sdc_idle;
            cnt_q <= '0;
            shin_q <= `SDC_WORD_RST;
            shout_q <= `SDC_WORD_RST;
            loaded_q <= 1'b0;
            sdo_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shin_q <= shin_d;
            shout_q <= shout_d;
            loaded_q <= loaded_d;
            sdo_q <= sdo_d;
            oe_n_q <= oe_n_d;
        end
    end

    // Register commit, standby and start-up timer
    always_comb begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        active_d = active_q;
        nr_d = (nr_q != '0) ? nr_q - `SDC_STARTUP_W'(1) : nr_q;
        clear = 1'b0;
        if (commit) begin
            if (shin_q[`SDC_BIT_SEL]) begin
                ctrl1_d = shin_q;
            end else begin
                ctrl0_d = shin_q;
            end
            clear = shin_q[`SDC_BIT_CLEAR];
            if (shin_q[`SDC_BIT_ENABLE]) begin
                active_d = 1'b1;
                if (!active_q) begin
                    nr_d = `SDC_STARTUP_W'(`SDC_STARTUP_CYC);
                end
            end else begin
                active_d = 1'b0;
                ctrl0_d = `SDC_WORD_RST;
                ctrl1_d = `SDC_WORD_RST;
                nr_d = '0;
                clear = 1'b1;
            end
        end
        not_ready = (nr_q != '0);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl0_q <= `SDC_WORD_RST;
            ctrl1_q <= `SDC_WORD_RST;
            active_q <= 1'b0;
            nr_q <= '0;
        end else begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            active_q <= active_d;
            nr_q <= nr_d;
        end
    end

    // Protection gating: per-driver overcurrent and retry, thermal and supply shared by all drivers
    always_comb begin
        oc_flags = st0[`SDC_ST_OC_HI:`SDC_ST_OC_LO];
        retry_en = ctrl1_q[`SDC_BIT_DRV_HI:`SDC_BIT_DRV_LO];
        tsd_flag = st0[`SDC_ST_TSD];
        supply_block = evt_s[`SDC_OL_N+1] | evt_s[`SDC_OL_N]
            | (ctrl0_q[`SDC_BIT_SUPPLY_LATCH] & (st0[`SDC_ST_UV] | st0[`SDC_ST_OV]));
    end

    // Per-driver enable
    genvar gi;
    generate
        for (gi = 0; gi < `SDC_DRV_N; gi++) begin : g_drv
            assign drv_d[gi] = active_q & ~not_ready & ctrl0_q[`SDC_BIT_DRV_LO+gi]
                & ~(oc_flags[gi] & ~retry_en[gi])
                & ~tsd_flag & ~supply_block;
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            drv_q <= '0;
        end else begin
            drv_q <= drv_d;
        end
    end

    // Outputs, all from flip-flops
    assign serial_out = sdo_q;
    assign serial_out_oe_n = oe_n_q;
    assign driver_on = drv_q;
    assign current_monitor_output = ctrl0_q[`SDC_BIT_CM_HI:`SDC_BIT_CM_LO];
    assign overcurrent_retry_duty = ctrl0_q[`SDC_BIT_RETRY_DUTY];
    assign overcurrent_retry_en = ctrl1_q[`SDC_BIT_DRV_HI:`SDC_BIT_DRV_LO];
    assign active_mode = active_q;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_oe_release;
        csn_s |=> serial_out_oe_n;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("output driven while deselected");

    property p_poll_fault;
        (state_q == sdc_idle && !csn_s) |=> serial_out == $past(fault);
    endproperty
    a_poll_fault: assert property (p_poll_fault) else $error("polled fault bit wrong");

    property p_bad_count;
        (state_q == sdc_frame && csn_rise && cnt_q != `SDC_CNT_W'(`SDC_FRAME_BITS))
            |=> ##1 (ctrl0_q == $past(ctrl0_q, 2) && ctrl1_q == $past(ctrl1_q, 2));
    endproperty
    a_bad_count: assert property (p_bad_count) else $error("wrong-length frame committed");

    property p_good_write;
        (commit && !shin_q[`SDC_BIT_SEL] && shin_q[`SDC_BIT_ENABLE]) |=> ctrl0_q == $past(shin_q);
    endproperty
    a_good_write: assert property (p_good_write) else $error("valid frame not written");

    property p_standby;
        (commit && !shin_q[`SDC_BIT_ENABLE]) |=> (!active_mode && ctrl0_q == '0 && ctrl1_q == '0) ##1 driver_on == '0;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");

    property p_always_one;
        (state_q == sdc_frame && sck_rise && !loaded_q && !sdi_s) |=> shout_q[`SDC_ST_ALWAYS1];
    endproperty
    a_always_one: assert property (p_always_one) else $error("status bit 23 not one");

    property p_count_restart;
        (state_q == sdc_idle && csn_fall) |=> cnt_q == '0;
    endproperty
    a_count_restart: assert property (p_count_restart) else $error("bit count not restarted");

    property p_shift_in;
        (state_q == sdc_frame && !csn_rise && sck_rise) |=> shin_q[`SDC_FRAME_BITS-1] == $past(sdi_s);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("input bit not shifted");

    property p_load_status;
        (state_q == sdc_frame && !csn_rise && sck_rise && !loaded_q) |=> shout_q == $past(sdi_s ? st1 : st0);
    endproperty
    a_load_status: assert property (p_load_status) else $error("status word not loaded");

    property p_thermal_off;
        tsd_flag |=> driver_on == '0;
    endproperty
    a_thermal_off: assert property (p_thermal_off) else $error("driver on during shutdown");

    property p_oc_off;
        (oc_flags[0] && !retry_en[0]) |=> !driver_on[0];
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("driver on after overcurrent");

    c_commit: cover property (commit && shin_q[`SDC_BIT_ENABLE]);
    c_reject: cover property (state_q == sdc_frame && csn_rise && cnt_q != `SDC_CNT_W'(`SDC_FRAME_BITS)
        && cnt_q != '0);
    c_read_st1: cover property (state_q == sdc_frame && sck_rise && !loaded_q && sdi_s);
    c_clear: cover property (commit && shin_q[`SDC_BIT_CLEAR]);
endmodule // sdc_top

/* verification/sdc_host_model.sv */
// Host side of the link: mode 0 master, frames sent and read LSB first
module sdc_host_model (
    input wire logic clk_sys,
    output logic chip_select_n,
    output logic serial_clk,
    output logic serial_in,
    input wire logic serial_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle link: deselected, clock low
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end

    // Wait n system clocks, then step just past the edge
    task automatic gap(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One frame of n pulses; n other than 24 makes a refused frame
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rd);
        rd = 24'h000000;
        chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in = w[i % 24];
            gap(5);
            if (i < 24) rd[i] = serial_line;
            serial_clk = 1'b1;
            gap(4);
            serial_clk = 1'b0;
        end
        gap(5);
        // Poll without clocking shows only the fault bit
        if (n == 0) rd[0] = serial_line;
        chip_select_n = 1'b1;
        // Released data line must not keep its last value
        serial_in = ~serial_in;
        gap(6);
    endtask
endmodule // sdc_host_model

/* verification/tb_sdc_top.sv */
`include "sdc_defines.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_sdc_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] CTL = 24'haa0022;
    localparam logic [16:0] DRV = 17'h10011;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic chip_select_n;
    logic serial_clk;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe_n;
    wire serial_line;
    logic [16:0] overcurrent_evt = 17'h00000;
    logic temp_warn_evt = 1'b0;
    logic thermal_shutdown_evt = 1'b0;
    logic undervoltage_evt = 1'b0;
    logic overvoltage_evt = 1'b0;
    logic [21:0] openload_evt = 22'h000000;
    logic [16:0] driver_on;
    logic [1:0] current_monitor_output;
    logic overcurrent_retry_duty;
    logic [16:0] overcurrent_retry_en;
    logic active_mode;
    logic [23:0] rd;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    // Wire level of the data output
    assign serial_line = serial_out_oe_n ? 1'bz : serial_out;

    sdc_top dut_u (
        .clk_sys, .rst_n, .chip_select_n, .serial_clk, .serial_in, .serial_out,
        .serial_out_oe_n, .overcurrent_evt, .temp_warn_evt, .thermal_shutdown_evt,
        .undervoltage_evt, .overvoltage_evt, .openload_evt, .driver_on,
        .current_monitor_output, .overcurrent_retry_duty, .overcurrent_retry_en, .active_mode
    );

    sdc_host_model host_u (
        .clk_sys(clk_sys),
        .chip_select_n(chip_select_n),
        .serial_clk(serial_clk),
        .serial_in(serial_in),
        .serial_line(serial_line)
    );

    // System clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        host_u.gap(8);
        rst_n = 1'b1;
        host_u.gap(4);
        `CHK(active_mode, 1'b0)
        `CHK(driver_on, 17'h00000)
        host_u.xfer(CTL, 0, rd);
        `CHK(rd[0], 1'b0)
        `CHK(serial_line, 1'bz)
        `CHK(active_mode, 1'b0)
        host_u.xfer(CTL, 24, rd);
        `CHK(rd, 24'h800000)
        `CHK(active_mode, 1'b1)
        `CHK(current_monitor_output, 2'h2)
        `CHK(overcurrent_retry_duty, 1'b1)
        `CHK(driver_on, 17'h00000)
        host_u.gap(120);
        `CHK(driver_on, DRV)
        host_u.xfer(24'h000000, 23, rd);
        `CHK(active_mode, 1'b1)
        host_u.xfer(24'h000000, 25, rd);
        `CHK(active_mode, 1'b1)
        // Overcurrent on the first and fifth drivers
        overcurrent_evt = 17'h00011;
        host_u.gap(5);
        overcurrent_evt = 17'h00000;
        host_u.gap(5);
        `CHK(driver_on, 17'h10000)
        host_u.xfer(CTL, 0, rd);
        `CHK(rd[0], 1'b1)
        host_u.xfer(CTL, 24, rd);
        `CHK(rd, 24'h800023)
        host_u.xfer(CTL | 24'h400000, 24, rd);
        `CHK(rd, 24'h800023)
        host_u.xfer(CTL, 24, rd);
        `CHK(rd, 24'h800000)
        `CHK(driver_on, DRV)
        // Second register pair
        openload_evt = 22'h200001;
        host_u.gap(5);
        openload_evt = 22'h000000;
        host_u.xfer(24'h800023, 24, rd);
        `CHK(rd, 24'h400003)
        `CHK(overcurrent_retry_en, 17'h00011)
        host_u.xfer(CTL | 24'h400000, 24, rd);
        // Thermal shutdown releases every driver
        thermal_shutdown_evt = 1'b1;
        host_u.gap(5);
        thermal_shutdown_evt = 1'b0;
        host_u.gap(3);
        `CHK(driver_on, 17'h00000)
        host_u.xfer(CTL | 24'h400000, 24, rd);
        `CHK(driver_on, DRV)
        // Supply fault with automatic return
        undervoltage_evt = 1'b1;
        host_u.gap(5);
        `CHK(driver_on, 17'h00000)
        undervoltage_evt = 1'b0;
        host_u.gap(5);
        `CHK(driver_on, DRV)
        host_u.xfer(CTL | 24'h100000, 24, rd);
        `CHK(driver_on, 17'h00000)
        host_u.xfer(CTL | 24'h500000, 24, rd);
        `CHK(driver_on, DRV)
        // Overvoltage held off by bit 20, warning only reported
        overvoltage_evt = 1'b1;
        temp_warn_evt = 1'b1;
        host_u.gap(5);
        `CHK(driver_on, 17'h00000)
        overvoltage_evt = 1'b0;
        temp_warn_evt = 1'b0;
        host_u.gap(5);
        `CHK(driver_on, 17'h00000)
        host_u.xfer(CTL | 24'h400000, 24, rd);
        `CHK(rd, 24'hc80001)
        `CHK(driver_on, DRV)
        // Reset in mid-run returns to standby
        rst_n = 1'b0;
        host_u.gap(8);
        rst_n = 1'b1;
        host_u.gap(4);
        `CHK(active_mode, 1'b0)
        `CHK(driver_on, 17'h00000)
        `CHK(serial_line, 1'bz)
        host_u.xfer(CTL, 24, rd);
        `CHK(rd, 24'h800000)
        `CHK(active_mode, 1'b1)
        // Back to standby
        host_u.xfer(24'h000000, 24, rd);
        `CHK(active_mode, 1'b0)
        `CHK(driver_on, 17'h00000)
        `CHK(overcurrent_retry_en, 17'h00000)
        `CHK(current_monitor_output, 2'h0)
        `CHK(overcurrent_retry_duty, 1'b0)
        print_verdict();
    end
endmodule // tb_sdc_top
